//--- core/itr_divider.sv
// Purpose: restoring unsigned divider, one quotient bit per clock
// Assumes: operands stable only at start_i
// Notes: a zero divisor returns an all-ones quotient
`timescale 1ns/1ps
`default_nettype none
module itr_divider #(
	parameter int NUM_W = 24,
	parameter int DEN_W = 12
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// operands
	input wire logic start_i,
	input wire logic [NUM_W-1:0] num_i,
	input wire logic [DEN_W-1:0] den_i,
	// result
	output logic done_o,
	output logic [NUM_W-1:0] quot_o
);
	logic [NUM_W-1:0] num;
	logic [DEN_W:0] rem;
	logic [DEN_W-1:0] den;
	logic [$clog2(NUM_W+1)-1:0] count;
	logic busy;
	wire logic [DEN_W:0] shifted_rem = {rem[DEN_W-1:0], num[NUM_W-1]};
	wire logic fits = shifted_rem >= {1'b0, den};
	wire logic [DEN_W:0] next_rem = fits ? shifted_rem - {1'b0, den} : shifted_rem;
	wire logic last = busy && (count == $bits(count)'(1));

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			num <= '0;
			rem <= '0;
			den <= '0;
			count <= '0;
			busy <= 1'b0;
			done_o <= 1'b0;
			quot_o <= '0;
		end else begin
			done_o <= last;
			if (start_i && !busy) begin
				num <= num_i;
				den <= den_i;
				rem <= '0;
				count <= $bits(count)'(NUM_W);
				busy <= 1'b1;
			end else if (busy) begin
				rem <= next_rem;
				num <= {num[NUM_W-2:0], fits};
				count <= count - $bits(count)'(1);
				busy <= !last;
				if (last) begin
					quot_o <= (den == '0) ? '1 : {num[NUM_W-2:0], fits};
				end
			end
		end
	end
endmodule : itr_divider
`default_nettype wire

//--- core/itr_readback.sv
// Purpose: input voltage, current, power and local voltage value registers
// Assumes: converter codes and modulation ratio come from logic on clk_i
// Notes: a new sample set is published all at once after the divide
`timescale 1ns/1ps
`default_nettype none
`include "itr_cfg.svh"
module itr_readback #(
	parameter int ADC_W = 12,
	parameter int DUTY_W = 12
) (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// converter samples
	input wire logic sample_valid_i,
	input wire logic [ADC_W-1:0] local_voltage_sense_i,
	input wire logic [ADC_W-1:0] primary_current_sense_i,
	input wire logic [DUTY_W-1:0] modulation_ratio_i,
	// byte read port
	input wire logic rd_strobe_i,
	input wire itr_pkg::itr_byte_t rd_addr_i,
	output itr_pkg::itr_byte_t rd_data_o,
	output logic rd_valid_o,
	// status
	output logic sample_busy_o
);
	import itr_pkg::*;

	localparam int NUM_W = ADC_W + DUTY_W;
	localparam int PROD_W = 16 + ADC_W;

	itr_state_t state;
	itr_state_t next_state;
	logic [ADC_W-1:0] held_voltage;
	logic [ADC_W-1:0] held_current;
	logic [DUTY_W-1:0] held_ratio;
	logic [15:0] derived_input_voltage;
	logic [15:0] input_current_reading;
	logic [15:0] input_power_reading;
	logic [15:0] local_output_voltage;
	logic [7:0] low_shadow;
	logic low_pending;
	itr_byte_t pending_addr;
	logic div_done;
	logic [NUM_W-1:0] quotient;

	// current code falls as the sense voltage rises
	wire logic [ADC_W+11:0] current_scaled =
		(ADC_W+12)'(held_current) * (ADC_W+12)'(`ITR_CURRENT_GAIN);
	wire logic [ADC_W-1:0] current_drop =
		current_scaled[`ITR_CURRENT_GAIN_SHIFT +: ADC_W];
	wire logic [ADC_W-1:0] current_code =
		ADC_W'(`ITR_CURRENT_ZERO_CODE) - current_drop;

	// the quotient saturates rather than wrap when the ratio is small
	wire logic quot_over = |quotient[NUM_W-1:16];
	wire logic [15:0] quot_value = quot_over ? `ITR_SATURATED : quotient[15:0];
	wire logic [PROD_W-1:0] power_full = PROD_W'(quot_value) * PROD_W'(current_code);
	wire logic [15:0] power_value = power_full[`ITR_POWER_SHIFT +: 16];

	// 12-bit readings are left justified, low nibble reserved
	wire logic [15:0] current_word = {current_code, `ITR_RESERVED_NIBBLE};
	wire logic [15:0] voltage_word = {held_voltage, `ITR_RESERVED_NIBBLE};

	itr_divider #(
		.NUM_W(NUM_W),
		.DEN_W(DUTY_W)
	) u_divider (
		.clk_i(clk_i),
		.reset_n_i(reset_n_i),
		.start_i(state == ITR_IDLE && sample_valid_i),
		.num_i({held_voltage_now(local_voltage_sense_i), {DUTY_W{1'b0}}}),
		.den_i(modulation_ratio_i),
		.done_o(div_done),
		.quot_o(quotient)
	);

	function automatic logic [ADC_W-1:0] held_voltage_now(input logic [ADC_W-1:0] v);
		return v;
	endfunction : held_voltage_now

	always_comb begin
		next_state = state;
		case (state)
			ITR_IDLE: begin
				if (sample_valid_i) begin
					next_state = ITR_DIVIDE;
				end
			end
			ITR_DIVIDE: begin
				if (div_done) begin
					next_state = ITR_UPDATE;
				end
			end
			ITR_UPDATE: next_state = ITR_IDLE;
			default: next_state = ITR_IDLE;
		endcase
	end

	assign sample_busy_o = state != ITR_IDLE;

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			state <= ITR_IDLE;
			held_voltage <= '0;
			held_current <= '0;
			held_ratio <= '0;
		end else begin
			state <= next_state;
			if (state == ITR_IDLE && sample_valid_i) begin
				held_voltage <= local_voltage_sense_i;
				held_current <= primary_current_sense_i;
				held_ratio <= modulation_ratio_i;
			end
		end
	end

	// all four values move together so a host never mixes two samples
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			derived_input_voltage <= `ITR_VALUE_RESET;
			input_current_reading <= `ITR_VALUE_RESET;
			input_power_reading <= `ITR_VALUE_RESET;
			local_output_voltage <= `ITR_VALUE_RESET;
		end else if (state == ITR_UPDATE) begin
			derived_input_voltage <= quot_value;
			input_current_reading <= current_word;
			input_power_reading <= power_value;
			local_output_voltage <= voltage_word;
		end
	end

	// register selection
	wire logic hit_vin = rd_addr_i == `ITR_OFF_DERIVED_INPUT_VOLTAGE;
	wire logic hit_cur = rd_addr_i == `ITR_OFF_INPUT_CURRENT_READING;
	wire logic hit_pwr = rd_addr_i == `ITR_OFF_INPUT_POWER_READING;
	wire logic hit_vloc = rd_addr_i == `ITR_OFF_LOCAL_OUTPUT_VOLTAGE;
	wire logic mapped = hit_vin || hit_cur || hit_pwr || hit_vloc;
	wire logic [15:0] selected_word =
		hit_vin ? derived_input_voltage :
		hit_cur ? input_current_reading :
		hit_pwr ? input_power_reading :
		hit_vloc ? local_output_voltage : 16'h0000;
	// second read of the same register takes the frozen low byte
	wire logic second_read = low_pending && (pending_addr == rd_addr_i);
	wire itr_byte_t next_rd_data =
		!mapped ? `ITR_UNMAPPED_DATA :
		second_read ? low_shadow : selected_word[15:8];

	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rd_data_o <= 8'h00;
			rd_valid_o <= 1'b0;
			low_shadow <= 8'h00;
			low_pending <= 1'b0;
			pending_addr <= 8'h00;
		end else begin
			rd_valid_o <= rd_strobe_i;
			if (rd_strobe_i) begin
				rd_data_o <= next_rd_data;
				// a read elsewhere abandons a half-read value
				low_pending <= mapped && !second_read;
				pending_addr <= rd_addr_i;
				if (mapped && !second_read) begin
					low_shadow <= selected_word[7:0];
				end
			end
		end
	end

	// ratio copy is kept for debug visibility of the divisor used
	wire logic unused_ratio = ^held_ratio;
endmodule : itr_readback
`default_nettype wire

//--- inc/itr_cfg.svh
// What this block does
// - input voltage value is local sense voltage divided by present modulation ratio
// - each 16-bit value reads as two consecutive bytes, upper byte first
// - 12-bit readings sit in bits 15:4, bits 3:0 read as zero
// - input current is 12-bit from current sense, 337 uV per code
// - current code falls with sense voltage: 0 V gives 0xF10, 1 V 0xB98
// - input power value is derived input voltage times input current, upper byte first
// - local output voltage is 12-bit, 378 uV per code, 1 V reads 0xA53
//
// Purpose: offsets, field positions and scaling constants of the telemetry readback
// Assumes: byte-wide register read port, 12-bit converter codes
// Notes: definitions only
`ifndef ITR_CFG_SVH
`define ITR_CFG_SVH

`define ITR_OFF_DERIVED_INPUT_VOLTAGE 8'h12
`define ITR_OFF_INPUT_CURRENT_READING 8'h13
`define ITR_OFF_INPUT_POWER_READING 8'h14
`define ITR_OFF_LOCAL_OUTPUT_VOLTAGE 8'h15

`define ITR_READING_LSB 4
`define ITR_RESERVED_NIBBLE 4'h0
`define ITR_VALUE_RESET 16'h0000
`define ITR_UNMAPPED_DATA 8'h00

`define ITR_CURRENT_ZERO_CODE 12'hF10
`define ITR_CURRENT_GAIN 12'h4CA
`define ITR_CURRENT_GAIN_SHIFT 12
`define ITR_POWER_SHIFT 12
`define ITR_SATURATED 16'hFFFF

`endif

//--- inc/itr_pkg.sv
// Purpose: types shared by the telemetry readback files
// Assumes: nothing beyond the cfg header
// Notes: states carry explicit binary codes
package itr_pkg;
	typedef enum logic [1:0] {
		ITR_IDLE = 2'b00,
		ITR_DIVIDE = 2'b01,
		ITR_UPDATE = 2'b10
	} itr_state_t;

	typedef logic [7:0] itr_byte_t;
endpackage : itr_pkg

//--- tb/input_telemetry_readback_tb.sv
// Purpose: self-checking bench of the telemetry readback
// Assumes: 125 MHz clock, seed 77
// Notes: junk samples are offered while busy
`timescale 1ns/1ps
`default_nettype none
module input_telemetry_readback_tb;
	import itr_pkg::*;
	logic clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic sample_valid_i = 1'b0;
	logic [11:0] vs = 12'h000;
	logic [11:0] cs = 12'h000;
	logic [11:0] mr = 12'h000;
	logic rd_strobe_i;
	logic rd_valid_o;
	logic sample_busy_o;
	itr_byte_t rd_addr_i;
	itr_byte_t rd_data_o;
	int bad_count = 0;
	int cmp_count = 0;
	always #4 clk_i = ~clk_i;
	itr_readback i_itr_readback (.clk_i, .reset_n_i, .sample_valid_i,
		.local_voltage_sense_i(vs), .primary_current_sense_i(cs), .modulation_ratio_i(mr),
		.rd_strobe_i, .rd_addr_i, .rd_data_o, .rd_valid_o, .sample_busy_o);
	itr_host_model i_itr_host_model (.clk_i, .rd_strobe_o(rd_strobe_i), .rd_addr_o(rd_addr_i),
		.rd_data_i(rd_data_o));
	function automatic logic [15:0] f_vin(input logic [11:0] v, input logic [11:0] r);
		logic [31:0] q;
		q = (r == 12'h000) ? 32'h0000FFFF : ({20'h00000, v} << 12) / {20'h00000, r};
		return (q > 32'h0000FFFF) ? 16'hFFFF : q[15:0];
	endfunction : f_vin
	function automatic logic [11:0] f_cur(input logic [11:0] c);
		logic [23:0] p;
		p = {12'h000, c} * 24'h0004CA;
		return 12'hF10 - p[23:12];
	endfunction : f_cur
	function automatic logic [15:0] f_pow(input logic [15:0] v, input logic [11:0] c);
		logic [27:0] p;
		p = {12'h000, v} * {16'h0000, c};
		return p[27:12];
	endfunction : f_pow
	task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	task automatic test_done;
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : test_done
	// inverted inputs stay offered for the first four busy cycles and must be ignored
	task automatic samp(input logic [11:0] v, input logic [11:0] c, input logic [11:0] r);
		@(posedge clk_i);
		sample_valid_i <= 1'b1;
		{vs, cs, mr} <= {v, c, r};
		@(posedge clk_i);
		{vs, cs, mr} <= ~{v, c, r};
		repeat (4) @(posedge clk_i);
		sample_valid_i <= 1'b0;
		repeat (24) @(posedge clk_i);
	endtask : samp
	initial begin
		logic [15:0] g;
		logic [11:0] tv;
		logic [11:0] tc;
		logic [11:0] tr;
		itr_byte_t h;
		itr_byte_t l;
		void'($urandom(77));
		repeat (2) @(posedge clk_i);
		reset_n_i <= 1'b1;
		i_itr_host_model.read16(8'h12, g);
		chk("reset value", 16'h0000, g);
		for (int i = 0; i < 10; i++) begin
			{tv, tc, tr} = {12'($urandom), 12'($urandom), 12'($urandom)};
			case (i)
				0: {tv, tc, tr} = {12'hA53, 12'h000, 12'h800};
				1: {tv, tc, tr} = {12'hF7C, 12'hB97, 12'h000};
				2: {tv, tc, tr} = {12'h000, 12'hFFF, 12'h001};
				default: ;
			endcase
			samp(tv, tc, tr);
			i_itr_host_model.read16(8'h12, g);
			chk("input voltage", f_vin(tv, tr), g);
			i_itr_host_model.read16(8'h13, g);
			chk("input current", {f_cur(tc), 4'h0}, g);
			i_itr_host_model.read16(8'h14, g);
			chk("input power", f_pow(f_vin(tv, tr), f_cur(tc)), g);
			i_itr_host_model.read16(8'h15, g);
			chk("local voltage", {tv, 4'h0}, g);
		end
		samp(12'h5A7, 12'h100, 12'h400);
		i_itr_host_model.rd8(8'h15, h);
		samp(12'h3C1, 12'h100, 12'h400);
		i_itr_host_model.rd8(8'h15, l);
		chk("held pair", 16'h5A70, {h, l});
		i_itr_host_model.rd8(8'h12, h);
		i_itr_host_model.rd8(8'h40, l);
		chk("unmapped", 16'h0000, {8'h00, l});
		i_itr_host_model.rd8(8'h12, l);
		g = f_vin(12'h3C1, 12'h400);
		chk("fresh first", {g[15:8], g[15:8]}, {h, l});
		test_done();
	end
	initial begin
		repeat (5000) @(posedge clk_i);
		bad_count++;
		test_done();
	end
endmodule : input_telemetry_readback_tb
`default_nettype wire

//--- tb/itr_checker.sv
// Purpose: port checks of the telemetry readback
// Assumes: read and sample timing as handed over
// Notes: bound after endmodule
`timescale 1ns/1ps
`default_nettype none
module itr_checker (
	// clock and reset
	input wire logic clk_i,
	input wire logic reset_n_i,
	// sample port
	input wire logic sample_valid_i,
	input wire logic sample_busy_o,
	// read port
	input wire logic rd_strobe_i,
	input wire itr_pkg::itr_byte_t rd_addr_i,
	input wire itr_pkg::itr_byte_t rd_data_o,
	input wire logic rd_valid_o
);
	import itr_pkg::*;
	logic pend;
	itr_byte_t paddr;
	wire logic mapped = rd_addr_i >= 8'h12 && rd_addr_i <= 8'h15;
	default clocking @(posedge clk_i); endclocking
	default disable iff (!reset_n_i);
	// pend: next read of paddr returns the held low byte
	always_ff @(posedge clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			pend <= 1'b0;
			paddr <= 8'h00;
		end else if (rd_strobe_i) begin
			pend <= mapped && !(pend && rd_addr_i == paddr);
			paddr <= rd_addr_i;
		end
	end
	a_read_answer:
		assert property (rd_strobe_i |=> rd_valid_o) else $error("read unanswered");
	a_valid_cause:
		assert property (rd_valid_o |-> $past(rd_strobe_i)) else $error("stray valid");
	a_data_holds:
		assert property (!rd_strobe_i |=> $stable(rd_data_o)) else $error("data moved");
	a_unmapped_zero:
		assert property (rd_strobe_i && !mapped |=> rd_data_o == 8'h00) else $error("unmapped");
	a_reserved_nibble:
		assert property (rd_strobe_i && pend && rd_addr_i == paddr && rd_addr_i[0]
			|=> rd_data_o[3:0] == 4'h0) else $error("reserved nibble");
	a_busy_span:
		assert property ($rose(sample_busy_o) |-> sample_busy_o[*8] ##18 sample_busy_o
			##1 !sample_busy_o) else $error("busy span");
	a_busy_cause:
		assert property ($rose(sample_busy_o) |-> $past(sample_valid_i)) else $error("busy cause");
	a_accept_idle:
		assert property (sample_valid_i && !sample_busy_o |=> sample_busy_o) else $error("no accept");
endmodule : itr_checker
bind itr_readback itr_checker i_itr_checker (.clk_i, .reset_n_i, .sample_valid_i,
	.sample_busy_o, .rd_strobe_i, .rd_addr_i, .rd_data_o, .rd_valid_o);
`default_nettype wire

//--- tb/itr_host_model.sv
// Purpose: host reading the value registers byte by byte
// Assumes: one-cycle strobe, answer on the next edge
// Notes: the address is inverted once released
`timescale 1ns/1ps
`default_nettype none
module itr_host_model (
	// clock
	input wire logic clk_i,
	// read port
	output var logic rd_strobe_o,
	output var itr_pkg::itr_byte_t rd_addr_o,
	input wire itr_pkg::itr_byte_t rd_data_i
);
	import itr_pkg::*;
	initial rd_strobe_o = 1'b0;
	initial rd_addr_o = 8'h00;
	task automatic rd8(input itr_byte_t a, output itr_byte_t d);
		@(posedge clk_i);
		rd_strobe_o <= 1'b1;
		rd_addr_o <= a;
		@(posedge clk_i);
		rd_strobe_o <= 1'b0;
		rd_addr_o <= ~a;
		#1 d = rd_data_i;
	endtask : rd8
	// upper byte first; scaling by 2643 stays in host software
	task automatic read16(input itr_byte_t a, output logic [15:0] v);
		rd8(a, v[15:8]);
		rd8(a, v[7:0]);
	endtask : read16
endmodule : itr_host_model
`default_nettype wire
